//--- logic/gpp_regs.svh
/*
  Register offsets, reset values and bus codes of the eight-pin I/O port.
  Assumes a 4 KB register window per port instance on an AXI4-Lite bus.
*/
`ifndef GPP_REGS_SVH
`define GPP_REGS_SVH

// ==========================================================================
// Register offsets (byte addresses inside the port window)
`define GPP_OFF_DATA_LAST  12'h3FC
`define GPP_OFF_DIR        12'h400
`define GPP_OFF_SENSE      12'h404
`define GPP_OFF_BOTH       12'h408
`define GPP_OFF_EVENT      12'h40C
`define GPP_OFF_IRQ_MASK   12'h410
`define GPP_OFF_RAW_STAT   12'h414
`define GPP_OFF_MASK_STAT  12'h418
`define GPP_OFF_IRQ_CLEAR  12'h41C
`define GPP_OFF_ALT_SEL    12'h420
`define GPP_OFF_DRV_LOW    12'h500
`define GPP_OFF_DRV_MID    12'h504
`define GPP_OFF_DRV_HIGH   12'h508
`define GPP_OFF_OPEN_DRAIN 12'h50C
`define GPP_OFF_PULL_UP    12'h510
`define GPP_OFF_PULL_DOWN  12'h514
`define GPP_OFF_SLEW       12'h518
`define GPP_OFF_DIG_EN     12'h51C
`define GPP_OFF_ID_FIRST   12'hFD0

// ==========================================================================
// Field positions
`define GPP_DATA_MASK_LSB  2
`define GPP_ID_SLOT_FIRST  4'h4

// ==========================================================================
// Reset values
`define GPP_RST_ZERO       8'h00
`define GPP_RST_DRV_LOW    8'hFF
`define GPP_RST_PULL_UP    8'hFF
`define GPP_RST_DIG_EN     8'hFF
// Identification bytes, twelve slots from low offset up; values arbitrary
`define GPP_RST_ID_BYTES   96'hC3_A5_96_5A_3C_69_E1_1E_78_87_4B_B4

// ==========================================================================
// Bus response codes
`define GPP_RESP_OKAY      2'h0
`define GPP_RESP_SLVERR    2'h2

`endif

//--- logic/gpp_pkg.sv
/*
  Types shared by the I/O port and its pin synchroniser.
  Assumes eight pins per port and a 12-bit register address.
*/
package gpp_pkg;

  localparam int GPP_PINS = 8;
  localparam int GPP_AW   = 12;

  typedef struct packed {
    logic [7:0]        s1;
    logic [7:0]        s2;
  } gpp_sync_t;

  typedef struct packed {
    logic [7:0]        data, dir, sense, both, event_pol, im, ris, afsel;
    logic [7:0]        dr_low, dr_mid, dr_high, odr, pur, pdr, slr, den;
    logic [7:0]        prev, pin_in, pin_out, pin_oe;
    logic              irq, trig;
    logic              aw_got, w_got, wstrb0, bvalid, awready, wready;
    logic              arready, rvalid;
    logic [GPP_AW-1:0] awaddr;
    logic [7:0]        wdata;
    logic [1:0]        bresp, rresp;
    logic [31:0]       rdata;
  } gpp_state_t;

endpackage : gpp_pkg

//--- logic/gpp_sync.sv
/*
  Two-stage synchroniser for the eight port pins.
  Assumes pins change with no relation to clk_i.
*/
`timescale 1ns/100ps
module gpp_sync
  import gpp_pkg::*;
(
  input  wire logic       clk_i,   // System clock
  input  wire logic       nrst_i,  // Async reset, active low
  input  wire logic [7:0] d_i,     // Raw pin levels
  output logic      [7:0] q_o      // Synchronised levels
);

  gpp_sync_t st, nx;

  // Stage one feeds stage two only
  always_comb begin
    nx    = st;
    nx.s1 = d_i;
    nx.s2 = st.s1;
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st <= '0;
    end else begin
      st <= nx;
    end
  end

  assign q_o = st.s2;

endmodule : gpp_sync

//--- logic/gpp_port.sv
/*
  Eight-pin general-purpose I/O port with masked data access, per-pin
  interrupt triggers, alternate-function select, pad settings and ID bytes.
  Assumes an AXI4-Lite master on clk_i and pads outside that resolve
  pin_out_o/pin_oe_o onto the wire.
*/
`include "gpp_regs.svh"
`timescale 1ns/100ps
module gpp_port
  import gpp_pkg::*;
#(
  parameter logic [7:0]  PIN_MASK  = 8'hFF,             // Pins bonded to a pad
  parameter logic [7:0]  AFSEL_RST = `GPP_RST_ZERO,     // Debug pins of this port
  parameter bit          TRIG_EN   = 1'b0,              // Port drives converter trigger
  parameter int          TRIG_PIN  = 4,                 // Pin feeding the trigger
  parameter logic [95:0] ID_BYTES  = `GPP_RST_ID_BYTES  // Identification, arbitrary
) (
  input  wire logic              clk_i,            // System clock, 100 MHz
  input  wire logic              nrst_i,           // Power-on or external reset, low
  input  wire logic [GPP_AW-1:0] s_axi_awaddr_i,   // Write address
  input  wire logic              s_axi_awvalid_i,  // Write address valid
  output logic                   s_axi_awready_o,  // Write address ready
  input  wire logic [31:0]       s_axi_wdata_i,    // Write data
  input  wire logic [3:0]        s_axi_wstrb_i,    // Byte strobes
  input  wire logic              s_axi_wvalid_i,   // Write data valid
  output logic                   s_axi_wready_o,   // Write data ready
  output logic [1:0]             s_axi_bresp_o,    // Write response
  output logic                   s_axi_bvalid_o,   // Write response valid
  input  wire logic              s_axi_bready_i,   // Write response ready
  input  wire logic [GPP_AW-1:0] s_axi_araddr_i,   // Read address
  input  wire logic              s_axi_arvalid_i,  // Read address valid
  output logic                   s_axi_arready_o,  // Read address ready
  output logic [31:0]            s_axi_rdata_o,    // Read data
  output logic [1:0]             s_axi_rresp_o,    // Read response
  output logic                   s_axi_rvalid_o,   // Read data valid
  input  wire logic              s_axi_rready_i,   // Read data ready
  input  wire logic [7:0]        pin_i,            // Pad input levels
  output logic      [7:0]        pin_out_o,        // Pad output levels
  output logic      [7:0]        pin_oe_o,         // Pad output enables
  input  wire logic [7:0]        periph_out_i,     // Alternate function outputs
  input  wire logic [7:0]        periph_oe_i,      // Alternate function enables
  output logic      [7:0]        periph_in_o,      // Synchronised pins to peripherals
  output logic      [7:0]        drive_low_o,      // Low drive strength select
  output logic      [7:0]        drive_mid_o,      // Mid drive strength select
  output logic      [7:0]        drive_high_o,     // High drive strength select
  output logic      [7:0]        open_drain_o,     // Open-drain select
  output logic      [7:0]        pull_up_o,        // Pull-up select
  output logic      [7:0]        pull_down_o,      // Pull-down select
  output logic      [7:0]        slew_ctrl_o,      // Slew-rate control select
  output logic      [7:0]        digital_en_o,     // Digital pad enable
  output logic                   irq_o,            // Port interrupt, high
  output logic                   conv_trig_o       // Converter trigger pulse
);

  // ========================================================================
  // State and reset image
  localparam gpp_state_t ST_RST = '{
    afsel:   AFSEL_RST & PIN_MASK,
    dr_low:  `GPP_RST_DRV_LOW & PIN_MASK,
    pur:     `GPP_RST_PULL_UP & PIN_MASK,
    den:     `GPP_RST_DIG_EN & PIN_MASK,
    awready: 1'b1,
    wready:  1'b1,
    arready: 1'b1,
    default: '0
  };

  gpp_state_t        st;
  gpp_state_t        nx;
  logic [7:0]        pin_sync;
  logic [7:0]        pin_s;
  logic [7:0]        rise;
  logic [7:0]        fall;
  logic [7:0]        edge_evt;
  logic [7:0]        lvl_act;
  logic [7:0]        icr_clr;
  logic [7:0]        wv;
  logic [7:0]        dmask;
  logic [7:0]        src_out;
  logic [7:0]        src_oe;
  logic [7:0]        rd;
  logic [1:0]        rresp;
  logic [GPP_AW-1:0] a;
  logic [GPP_AW-1:0] ra;
  logic [3:0]        id_slot;
  logic              wr_do;
  logic              wen;

  // ========================================================================
  // Pin synchroniser
  gpp_sync u_sync (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .d_i    (pin_i),
    .q_o    (pin_sync)
  );

  // ========================================================================
  // Next-state logic
  always_comb begin
    nx       = st;
    pin_s    = pin_sync & st.den & PIN_MASK;
    rise     = pin_s & ~st.prev;
    fall     = ~pin_s & st.prev;
    edge_evt = (st.both & (rise | fall))
             | (~st.both & ((st.event_pol & rise) | (~st.event_pol & fall)));
    lvl_act  = ~(st.event_pol ^ pin_s);
    icr_clr  = '0;
    wr_do    = st.aw_got & st.w_got;
    wen      = wr_do & st.wstrb0;
    wv       = st.wdata & PIN_MASK;
    a        = st.awaddr;
    dmask    = a[9:2];
    ra       = s_axi_araddr_i;
    id_slot  = ra[5:2] - `GPP_ID_SLOT_FIRST;
    rd       = '0;
    rresp    = `GPP_RESP_OKAY;
    nx.prev  = pin_s;
    nx.pin_in = pin_s;

    if (st.bvalid && s_axi_bready_i) begin
      nx.bvalid = 1'b0;
    end
    if (wr_do) begin
      nx.aw_got = 1'b0;
      nx.w_got  = 1'b0;
      nx.bvalid = 1'b1;
      nx.bresp  = `GPP_RESP_OKAY;
      if (a <= `GPP_OFF_DATA_LAST) begin
        if (wen) nx.data = (st.data & ~dmask) | (wv & dmask);
      end else if (a == `GPP_OFF_DIR) begin
        if (wen) nx.dir = wv;
      end else if (a == `GPP_OFF_SENSE) begin
        if (wen) nx.sense = wv;
      end else if (a == `GPP_OFF_BOTH) begin
        if (wen) nx.both = wv;
      end else if (a == `GPP_OFF_EVENT) begin
        if (wen) nx.event_pol = wv;
      end else if (a == `GPP_OFF_IRQ_MASK) begin
        if (wen) nx.im = wv;
      end else if (a == `GPP_OFF_IRQ_CLEAR) begin
        if (wen) icr_clr = wv;
      end else if (a == `GPP_OFF_ALT_SEL) begin
        if (wen) nx.afsel = wv;
      end else if (a == `GPP_OFF_DRV_LOW) begin
        // Drive selects are exclusive: setting one clears the others
        if (wen) begin
          nx.dr_low  = wv;
          nx.dr_mid  = st.dr_mid & ~wv;
          nx.dr_high = st.dr_high & ~wv;
        end
      end else if (a == `GPP_OFF_DRV_MID) begin
        if (wen) begin
          nx.dr_mid  = wv;
          nx.dr_low  = st.dr_low & ~wv;
          nx.dr_high = st.dr_high & ~wv;
        end
      end else if (a == `GPP_OFF_DRV_HIGH) begin
        if (wen) begin
          nx.dr_high = wv;
          nx.dr_low  = st.dr_low & ~wv;
          nx.dr_mid  = st.dr_mid & ~wv;
        end
      end else if (a == `GPP_OFF_OPEN_DRAIN) begin
        if (wen) nx.odr = wv;
      end else if (a == `GPP_OFF_PULL_UP) begin
        if (wen) begin
          nx.pur = wv;
          nx.pdr = st.pdr & ~wv;
        end
      end else if (a == `GPP_OFF_PULL_DOWN) begin
        if (wen) begin
          nx.pdr = wv;
          nx.pur = st.pur & ~wv;
        end
      end else if (a == `GPP_OFF_SLEW) begin
        if (wen) nx.slr = wv;
      end else if (a == `GPP_OFF_DIG_EN) begin
        if (wen) nx.den = wv;
      end else if (a == `GPP_OFF_RAW_STAT || a == `GPP_OFF_MASK_STAT
                   || a >= `GPP_OFF_ID_FIRST) begin
        // Read-only locations accept and drop the write
      end else begin
        nx.bresp = `GPP_RESP_SLVERR;
      end
    end

    // Input bits track the pin; output bits hold what software wrote
    nx.data = (nx.data & st.dir) | (pin_s & ~st.dir);

    // Level bits follow the pin; edge bits latch and a new edge beats a clear
    nx.ris = ((st.sense & lvl_act)
           | (~st.sense & ((st.ris & ~icr_clr) | edge_evt))) & PIN_MASK;

    if (s_axi_awvalid_i && st.awready) begin
      nx.aw_got = 1'b1;
      nx.awaddr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && st.wready) begin
      nx.w_got  = 1'b1;
      nx.wdata  = s_axi_wdata_i[7:0];
      nx.wstrb0 = s_axi_wstrb_i[0];
    end

    if (st.rvalid && s_axi_rready_i) begin
      nx.rvalid = 1'b0;
    end
    if (s_axi_arvalid_i && st.arready) begin
      if (ra <= `GPP_OFF_DATA_LAST) begin
        rd = st.data & ra[9:2];
      end else if (ra == `GPP_OFF_DIR) begin
        rd = st.dir;
      end else if (ra == `GPP_OFF_SENSE) begin
        rd = st.sense;
      end else if (ra == `GPP_OFF_BOTH) begin
        rd = st.both;
      end else if (ra == `GPP_OFF_EVENT) begin
        rd = st.event_pol;
      end else if (ra == `GPP_OFF_IRQ_MASK) begin
        rd = st.im;
      end else if (ra == `GPP_OFF_RAW_STAT) begin
        rd = st.ris;
      end else if (ra == `GPP_OFF_MASK_STAT) begin
        rd = st.ris & st.im;
      end else if (ra == `GPP_OFF_IRQ_CLEAR) begin
        rd = '0;
      end else if (ra == `GPP_OFF_ALT_SEL) begin
        rd = st.afsel;
      end else if (ra == `GPP_OFF_DRV_LOW) begin
        rd = st.dr_low;
      end else if (ra == `GPP_OFF_DRV_MID) begin
        rd = st.dr_mid;
      end else if (ra == `GPP_OFF_DRV_HIGH) begin
        rd = st.dr_high;
      end else if (ra == `GPP_OFF_OPEN_DRAIN) begin
        rd = st.odr;
      end else if (ra == `GPP_OFF_PULL_UP) begin
        rd = st.pur;
      end else if (ra == `GPP_OFF_PULL_DOWN) begin
        rd = st.pdr;
      end else if (ra == `GPP_OFF_SLEW) begin
        rd = st.slr;
      end else if (ra == `GPP_OFF_DIG_EN) begin
        rd = st.den;
      end else if (ra >= `GPP_OFF_ID_FIRST) begin
        rd = ID_BYTES[id_slot*8 +: 8];
      end else begin
        rresp = `GPP_RESP_SLVERR;
      end
      nx.rvalid = 1'b1;
      nx.rdata  = {24'h000000, rd};
      nx.rresp  = rresp;
    end

    // One write and one read in flight; readies are registered
    nx.awready = ~nx.aw_got & ~nx.bvalid;
    nx.wready  = ~nx.w_got & ~nx.bvalid;
    nx.arready = ~nx.rvalid;

    // Open drain only ever pulls low, so a high level releases the pad
    src_out    = (nx.afsel & periph_out_i) | (~nx.afsel & nx.data);
    src_oe     = (nx.afsel & periph_oe_i) | (~nx.afsel & nx.dir);
    nx.pin_out = src_out & ~nx.odr & PIN_MASK;
    nx.pin_oe  = src_oe & ~(nx.odr & src_out) & PIN_MASK;

    nx.irq  = |(nx.ris & nx.im);
    nx.trig = TRIG_EN & nx.im[TRIG_PIN] & nx.ris[TRIG_PIN]
            & ~st.ris[TRIG_PIN];
  end

  // Either reset source arrives here already merged into nrst_i
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st <= ST_RST;
    end else begin
      st <= nx;
    end
  end

  // ========================================================================
  // Outputs
  assign s_axi_awready_o = st.awready;
  assign s_axi_wready_o  = st.wready;
  assign s_axi_bresp_o   = st.bresp;
  assign s_axi_bvalid_o  = st.bvalid;
  assign s_axi_arready_o = st.arready;
  assign s_axi_rdata_o   = st.rdata;
  assign s_axi_rresp_o   = st.rresp;
  assign s_axi_rvalid_o  = st.rvalid;
  assign pin_out_o       = st.pin_out;
  assign pin_oe_o        = st.pin_oe;
  assign periph_in_o     = st.pin_in;
  assign drive_low_o     = st.dr_low;
  assign drive_mid_o     = st.dr_mid;
  assign drive_high_o    = st.dr_high;
  assign open_drain_o    = st.odr;
  assign pull_up_o       = st.pur;
  assign pull_down_o     = st.pdr;
  assign slew_ctrl_o     = st.slr;
  assign digital_en_o    = st.den;
  assign irq_o           = st.irq;
  assign conv_trig_o     = st.trig;

  // ========================================================================
  // Assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  a_reset_defaults: assert property (
    (nrst_i && !$past(nrst_i)) |-> (st.dir == '0 && st.afsel == (AFSEL_RST & PIN_MASK)))
    else $error("direction or function select wrong after reset");
  a_input_sampled: assert property (
    1'b1 |=> (((st.data ^ $past(pin_s)) & ~$past(st.dir)) == '0))
    else $error("input data bit does not follow the pin");
  a_masked_write: assert property (
    (wr_do && a <= `GPP_OFF_DATA_LAST)
      |=> (((st.data ^ $past(st.data)) & $past(st.dir) & ~$past(dmask)) == '0))
    else $error("data write changed an unmasked bit");
  a_masked_read: assert property (
    (s_axi_arvalid_i && st.arready && ra <= `GPP_OFF_DATA_LAST)
      |=> (s_axi_rvalid_o && (s_axi_rdata_o[7:0] & ~$past(ra[9:2])) == '0
           && s_axi_rdata_o[31:8] == '0))
    else $error("data read returned an unmasked bit");
  a_irq_merge: assert property (
    irq_o == |(st.ris & st.im))
    else $error("interrupt output disagrees with masked status");
  a_edge_latched: assert property (
    1'b1 |=> (($past(st.ris & ~st.sense & ~icr_clr) & st.sense) != '0
              || ($past(st.ris & ~st.sense & ~icr_clr) & ~st.ris) == '0))
    else $error("edge status lost without a clear");
  a_event_beats_clear: assert property (
    (|(edge_evt & icr_clr & ~st.sense)) |=> (|st.ris))
    else $error("edge in clearing cycle was lost");
  a_level_follow: assert property (
    1'b1 |=> (((st.ris ^ $past(lvl_act)) & $past(st.sense)) == '0))
    else $error("level status does not follow the pin");
  a_trig_pulse: assert property (
    conv_trig_o |-> (TRIG_EN && st.im[TRIG_PIN] && st.ris[TRIG_PIN]) ##1 !conv_trig_o)
    else $error("converter trigger without unmasked pin event");
  a_alt_drive: assert property (
    1'b1 |=> (((pin_out_o ^ $past(periph_out_i)) & $past(nx.afsel & ~nx.odr) & PIN_MASK)
              == '0))
    else $error("alternate function does not drive the pin");
  a_unbonded_bits: assert property (
    ((st.dir | st.im | st.ris | st.data) & ~PIN_MASK) == '0)
    else $error("unbonded pin bit holds a value");

  c_edge_irq:   cover property (|(edge_evt & ~st.sense & st.im) ##1 irq_o);
  c_data_write: cover property (wr_do && a <= `GPP_OFF_DATA_LAST && dmask != 8'hFF);
  c_conv_trig:  cover property (conv_trig_o);
  c_bad_read:   cover property (s_axi_rvalid_o && s_axi_rresp_o == `GPP_RESP_SLVERR);

endmodule : gpp_port

//--- verification/gpp_pad_model.sv
/*
  Pad-side model of the port: pins driven by the port, by an outside
  source, or left to the pull-up.
  Assumes the pull-up stays selected, as it is after reset.
*/
`timescale 1ns/100ps
// ==========================================================
// Pad wire resolution
module gpp_pad_model (
  input  wire logic [7:0] pin_out_i,  // Port output level
  input  wire logic [7:0] pin_oe_i,   // Port output enable
  input  wire logic [7:0] ext_i,      // Outside source level
  input  wire logic [7:0] ext_en_i,   // Outside source drives
  output logic      [7:0] pad_o       // Resolved pad level
);
  // Outside source holds its level until the bench changes it
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pad_o[i] = pin_oe_i[i] ? pin_out_i[i] : (ext_en_i[i] ? ext_i[i] : 1'b1);
    end
  end
endmodule : gpp_pad_model

//--- verification/gpp_port_bench.sv
/*
  Self-checking bench of the I/O port, set up as port B.
  Assumes the design files and the register header are compiled first.
*/
`timescale 1ns/100ps
`include "gpp_regs.svh"
module gpio_port_with_masked_data_and_irq_bench;
  logic        clk_i = 0, nrst_i = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
  logic [11:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, rv_d;
  logic [7:0]  ext = 0, ext_en = 0, p_out = 0, p_oe = 0, exp_d, m, d, k;
  logic [1:0]  resp;
  wire  [1:0]  br, rr;
  wire  [31:0] rdat;
  wire         awr, wrd, bv, arr, rv, irq, trig;
  wire  [7:0]  pout, poe, pad, p_in, drv_low, pull_up;
  wire  [7:0]  drv_mid, open_dr, pull_dn, slew, dig_en;
  int          errors = 0, checked = 0;
  logic        trig_seen = 0;

  initial forever #5 clk_i = ~clk_i;

  gpp_port #(.AFSEL_RST(8'h80), .TRIG_EN(1'b1)) u_dut (
    .clk_i(clk_i), .nrst_i(nrst_i), .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv),
    .s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hF),
    .s_axi_wvalid_i(wv), .s_axi_wready_o(wrd), .s_axi_bresp_o(br),
    .s_axi_bvalid_o(bv), .s_axi_bready_i(bry), .s_axi_araddr_i(ara),
    .s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_rdata_o(rdat),
    .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv), .s_axi_rready_i(rry), .pin_i(pad),
    .pin_out_o(pout), .pin_oe_o(poe), .periph_out_i(p_out), .periph_oe_i(p_oe),
    .periph_in_o(p_in), .drive_low_o(drv_low), .drive_mid_o(drv_mid), .drive_high_o(),
    .open_drain_o(open_dr), .pull_up_o(pull_up), .pull_down_o(pull_dn),
    .slew_ctrl_o(slew), .digital_en_o(dig_en), .irq_o(irq), .conv_trig_o(trig));

  gpp_pad_model u_pad (.pin_out_i(pout), .pin_oe_i(poe), .ext_i(ext),
    .ext_en_i(ext_en), .pad_o(pad));

  always @(posedge clk_i) if (trig === 1'b1) trig_seen <= 1'b1;

  // ==========================================================
  // Bus and compare tasks
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Masked data write: only bits whose mask bit is set take the new value
  function automatic logic [7:0] merge_wr(input logic [7:0] old, input logic [7:0] msk,
                                          input logic [7:0] val);
    return (old & ~msk) | (val & msk);
  endfunction : merge_wr

  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    int n;
    n = 0;
    awa <= a; wd <= {24'h0, v}; awv <= 1; wv <= 1; bry <= 1;
    do begin
      @(posedge clk_i); n++;
      if (awr === 1'b1) awv <= 0;
      if (wrd === 1'b1) wv <= 0;
    end while (bv !== 1'b1 && n < 50);
    resp = br;
    chk("write wait", n < 50, 1);
  endtask : wr

  task automatic rd(input logic [11:0] a);
    int n;
    n = 0;
    ara <= a; arv <= 1; rry <= 1;
    do begin
      @(posedge clk_i); n++;
      if (arr === 1'b1) arv <= 0;
    end while (rv !== 1'b1 && n < 50);
    rv_d = rdat; resp = rr;
    chk("read wait", n < 50, 1);
  endtask : rd

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict

  initial begin
    #400000; errors++;
    give_verdict;
  end

  // ==========================================================
  // Tests
  initial begin
    void'($urandom(59));
    repeat (2) @(posedge clk_i);
    nrst_i <= 1;
    repeat (3) @(posedge clk_i);
    rd(`GPP_OFF_DIR);     chk("dir", rv_d, 0);
    rd(`GPP_OFF_ALT_SEL); chk("alt sel", rv_d, 32'h80);
    rd(`GPP_OFF_DRV_LOW); chk("drive low", rv_d, 32'hFF);
    chk("pull up", pull_up, 8'hFF);
    chk("dig en", dig_en, 8'hFF);
    $display("test reset done");
    ext_en <= 8'hFF; ext <= 8'h5A;
    repeat (5) @(posedge clk_i);
    rd(12'h3FC); chk("data in", rv_d, 32'h5A);
    chk("periph in", p_in, 8'h5A);
    ext_en <= 0;
    wr(`GPP_OFF_ALT_SEL, 0); wr(`GPP_OFF_DIR, 8'hFF); wr(12'h3FC, 0);
    exp_d = 0;
    for (int i = 0; i < 12; i++) begin
      m = (i == 0) ? 8'h00 : 8'($urandom); d = 8'($urandom); k = 8'($urandom);
      wr({2'b00, m, 2'b00}, d);
      exp_d = merge_wr(exp_d, m, d);
      rd({2'b00, k, 2'b00}); chk("data masked", rv_d, {24'h0, exp_d & k});
      chk("pin out", pout, exp_d);
    end
    $display("test masked data done");
    p_out <= 8'($urandom); p_oe <= 8'hFF;
    wr(`GPP_OFF_ALT_SEL, 8'hFF);
    repeat (2) @(posedge clk_i);
    chk("pin alt", pout, p_out);
    chk("pin oe alt", poe, 8'hFF);
    wr(`GPP_OFF_ALT_SEL, 0); wr(`GPP_OFF_DIR, 0);
    p_oe <= 0; ext_en <= 8'hFF; ext <= 0;
    $display("test alt function done");
    // Mask stays off while the trigger is set up, a change could fire
    wr(`GPP_OFF_IRQ_MASK, 0); wr(`GPP_OFF_SENSE, 0); wr(`GPP_OFF_BOTH, 0);
    wr(`GPP_OFF_EVENT, 8'h10);
    // Pins fell when the outside source took over; drop those stale edges
    wr(`GPP_OFF_IRQ_CLEAR, 8'hFF);
    ext <= 8'h10;
    repeat (5) @(posedge clk_i);
    rd(`GPP_OFF_RAW_STAT);  chk("raw rise", rv_d, 32'h10);
    rd(`GPP_OFF_MASK_STAT); chk("masked off", rv_d, 0);
    chk("irq masked", irq, 0);
    ext <= 0;
    repeat (5) @(posedge clk_i);
    wr(`GPP_OFF_IRQ_CLEAR, 8'hEF);
    rd(`GPP_OFF_RAW_STAT); chk("raw latched", rv_d, 32'h10);
    wr(`GPP_OFF_IRQ_CLEAR, 8'h10);
    rd(`GPP_OFF_RAW_STAT); chk("raw cleared", rv_d, 0);
    wr(`GPP_OFF_IRQ_MASK, 8'h10);
    ext <= 8'h10;
    repeat (5) @(posedge clk_i);
    chk("irq edge", irq, 1);
    chk("conv trig", trig_seen, 1);
    rd(`GPP_OFF_MASK_STAT); chk("masked on", rv_d, 32'h10);
    wr(`GPP_OFF_IRQ_MASK, 0); wr(`GPP_OFF_IRQ_CLEAR, 8'h10);
    wr(`GPP_OFF_BOTH, 8'h10); wr(`GPP_OFF_IRQ_MASK, 8'h10);
    ext <= 0;
    repeat (5) @(posedge clk_i);
    chk("irq fall both", irq, 1);
    wr(`GPP_OFF_IRQ_MASK, 0); wr(`GPP_OFF_IRQ_CLEAR, 8'h10); wr(`GPP_OFF_SENSE, 8'h10);
    wr(`GPP_OFF_BOTH, 0); wr(`GPP_OFF_EVENT, 0); wr(`GPP_OFF_IRQ_MASK, 8'h10);
    repeat (5) @(posedge clk_i);
    chk("irq level low", irq, 1);
    ext <= 8'h10;
    repeat (5) @(posedge clk_i);
    chk("irq level gone", irq, 0);
    $display("test interrupts done");
    wr(12'h600, 8'h01); chk("unmapped wr", resp, `GPP_RESP_SLVERR);
    rd(12'h600); chk("unmapped rd", resp, `GPP_RESP_SLVERR);
    chk("unmapped data", rv_d, 0);
    wr(`GPP_OFF_ID_FIRST, 8'hFF);
    rd(`GPP_OFF_ID_FIRST); chk("ident", rv_d, {24'h0, 8'(`GPP_RST_ID_BYTES)});
    rd(12'hFFC); chk("ident last", rv_d, {24'h0, 8'(`GPP_RST_ID_BYTES >> 88)});
    wr(`GPP_OFF_DRV_MID, 8'h0F); wr(`GPP_OFF_OPEN_DRAIN, 8'h3C);
    wr(`GPP_OFF_PULL_DOWN, 8'h81); wr(`GPP_OFF_SLEW, 8'h55);
    chk("drive mid", drv_mid, 8'h0F);
    chk("drive low excl", drv_low, 8'hF0);
    chk("open drain", open_dr, 8'h3C);
    chk("pull down", pull_dn, 8'h81);
    chk("pull up excl", pull_up, 8'h7E);
    chk("slew", slew, 8'h55);
    $display("test map done");
    wr(`GPP_OFF_DIR, 8'hFF); wr(`GPP_OFF_ALT_SEL, 0);
    // Debug reset pin must see the pull-up, not a low, while reset is held
    ext_en <= 0;
    nrst_i <= 0;
    repeat (2) @(posedge clk_i);
    nrst_i <= 1;
    repeat (3) @(posedge clk_i);
    rd(`GPP_OFF_DIR);     chk("dir again", rv_d, 0);
    rd(`GPP_OFF_ALT_SEL); chk("alt again", rv_d, 32'h80);
    $display("test second reset done");
    give_verdict;
  end
endmodule : gpio_port_with_masked_data_and_irq_bench
